// ### hw/tcfe_device.sv
// device end: freeze mode entry gating and core power state keeping
`timescale 1ns/1ps
`default_nettype none
module tcfe_device (
   input  wire logic                         clk,         // core clock, 25 MHz
   input  wire logic                         rst_n,       // asynchronous reset, active low
   input  wire logic                         dual_mode,   // 1 two-condition, 0 request only
   input  wire logic                         core_power,  // core supply present
   input  wire logic                         state_we,    // user write to retained state
   input  wire logic [tcfe_pkg::STATE_W-1:0] state_wdata, // data for retained state
   input  wire logic                         restore_we,  // external restore load
   input  wire logic [tcfe_pkg::STATE_W-1:0] restore_data,// restored state from outside
   output logic      [tcfe_pkg::STATE_W-1:0] state_q,     // retained core state
   output logic                              frozen_out,  // freeze mode indicator
   tcfe_if.device                            lnk          // link to request pin and permit
);
   // ****************************************
   // level decode
   // ****************************************
   // pin and supply levels as active-high flags
   logic req_on;
   logic permit_on;
   logic power_on;

   always_comb begin
      req_on    = (lnk.low_power_request_pin_n == tcfe_pkg::REQ_ASSERTED);
      permit_on = (lnk.static_entry_permit == tcfe_pkg::PERMIT_ASSERTED);
      power_on  = (core_power == tcfe_pkg::CORE_POWER_ON);
   end

   // ****************************************
   // entry condition
   // ****************************************
   // permit only counts in the two-condition variant
   logic entry_ok;

   always_comb begin
      case (dual_mode)
         tcfe_pkg::VARIANT_DUAL: begin
            entry_ok = req_on && permit_on;
         end
         tcfe_pkg::VARIANT_SINGLE: begin
            entry_ok = req_on;
         end
         default: begin
            entry_ok = 1'h0;
         end
      endcase
   end

   // ****************************************
   // mode state machine
   // ****************************************
   tcfe_pkg::tcfe_state_e state;
   tcfe_pkg::tcfe_state_e next_state;

   // power loss outranks both entry and exit
   always_comb begin
      case (state)
         tcfe_pkg::TCFE_RUN: begin
            if (!power_on) begin
               next_state = tcfe_pkg::TCFE_UNPOWERED;
            end else if (entry_ok) begin
               next_state = tcfe_pkg::TCFE_FROZEN;
            end else begin
               next_state = tcfe_pkg::TCFE_RUN;
            end
         end
         tcfe_pkg::TCFE_FROZEN: begin
            if (!power_on) begin
               next_state = tcfe_pkg::TCFE_UNPOWERED;
            end else if (!req_on) begin
               next_state = tcfe_pkg::TCFE_RUN;
            end else begin
               next_state = tcfe_pkg::TCFE_FROZEN;
            end
         end
         tcfe_pkg::TCFE_UNPOWERED: begin
            if (power_on) begin
               next_state = tcfe_pkg::TCFE_RUN;
            end else begin
               next_state = tcfe_pkg::TCFE_UNPOWERED;
            end
         end
         default: begin
            next_state = tcfe_pkg::TCFE_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= tcfe_pkg::TCFE_RUN;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // retained state load select
   // ****************************************
   // power loss beats restore, restore beats a user write
   // restore may land in the edge that enters freeze
   logic clear_all;
   logic take_restore;
   logic take_write;

   always_comb begin
      case (state)
         tcfe_pkg::TCFE_RUN: begin
            if (!power_on) begin
               clear_all    = 1'h1;
               take_restore = 1'h0;
               take_write   = 1'h0;
            end else if (restore_we) begin
               clear_all    = 1'h0;
               take_restore = 1'h1;
               take_write   = 1'h0;
            end else if (state_we && !entry_ok) begin
               clear_all    = 1'h0;
               take_restore = 1'h0;
               take_write   = 1'h1;
            end else begin
               clear_all    = 1'h0;
               take_restore = 1'h0;
               take_write   = 1'h0;
            end
         end
         tcfe_pkg::TCFE_FROZEN: begin
            clear_all    = !power_on;
            take_restore = 1'h0;
            take_write   = 1'h0;
         end
         tcfe_pkg::TCFE_UNPOWERED: begin
            clear_all    = 1'h1;
            take_restore = 1'h0;
            take_write   = 1'h0;
         end
         default: begin
            clear_all    = 1'h0;
            take_restore = 1'h0;
            take_write   = 1'h0;
         end
      endcase
   end

   // ****************************************
   // retained state bits
   // ****************************************
   // one keep cell per retained bit
   logic [tcfe_pkg::STATE_W-1:0] next_state_q;

   for (genvar bit_idx = 0; bit_idx < tcfe_pkg::STATE_W; bit_idx++) begin : g_keep
      logic next_bit;
      always_comb begin
         if (clear_all) begin
            next_bit = tcfe_pkg::STATE_RESET[bit_idx];
         end else if (take_restore) begin
            next_bit = restore_data[bit_idx];
         end else if (take_write) begin
            next_bit = state_wdata[bit_idx];
         end else begin
            next_bit = state_q[bit_idx];
         end
      end
      assign next_state_q[bit_idx] = next_bit;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= tcfe_pkg::STATE_RESET;
      end else begin
         state_q <= next_state_q;
      end
   end

   // ****************************************
   // freeze indicator
   // ****************************************
   // follows next_state so the flag lines up with the mode
   logic next_frozen;

   always_comb begin
      next_frozen = (next_state == tcfe_pkg::TCFE_FROZEN);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frozen_out <= 1'h0;
         lnk.frozen <= 1'h0;
      end else begin
         frozen_out <= next_frozen;
         lnk.frozen <= next_frozen;
      end
   end
endmodule
`default_nettype wire

// ### hw/tcfe_if.sv
// link between the freeze entry device end and the user permit end
`timescale 1ns/1ps
`default_nettype none
interface tcfe_if;
   logic low_power_request_pin_n; // board request, active low
   logic static_entry_permit;     // permit from user logic, active high
   logic frozen;                  // device is in freeze mode
   modport device (input low_power_request_pin_n, input static_entry_permit, output frozen);
   modport user   (input low_power_request_pin_n, input frozen, output static_entry_permit);
endinterface
`default_nettype wire

// ### hw/tcfe_pkg.sv
// constants shared by the freeze entry device end and the user permit end
package tcfe_pkg;
   // request pin and permit levels
   localparam logic REQ_ASSERTED      = 1'h0;
   localparam logic REQ_IDLE          = 1'h1;
   localparam logic PERMIT_ASSERTED   = 1'h1;
   localparam logic PERMIT_IDLE       = 1'h0;
   // variant select: type 1 request only, type 2 request and permit
   localparam logic VARIANT_SINGLE    = 1'h0;
   localparam logic VARIANT_DUAL      = 1'h1;
   // core power present level
   localparam logic CORE_POWER_ON     = 1'h1;
   // retained state width and reset value
   localparam int   STATE_W           = 8;
   localparam logic [7:0] STATE_RESET = 8'h00;
   // device end states
   typedef enum logic [1:0] {TCFE_RUN, TCFE_FROZEN, TCFE_UNPOWERED} tcfe_state_e;
   // user end states
   typedef enum logic [1:0] {TCFE_U_IDLE, TCFE_U_HOUSEKEEP, TCFE_U_GRANT,
                             TCFE_U_REVOKE} tcfe_user_e;
endpackage

// ### hw/tcfe_user.sv
// user end: housekeeping then grant of the static entry permit
`timescale 1ns/1ps
`default_nettype none
module tcfe_user (
   input  wire logic clk,          // core clock, 25 MHz
   input  wire logic rst_n,        // asynchronous reset, active low
   input  wire logic busy,         // critical processing in progress
   output logic      permit_given, // mirror of permit output
   tcfe_if.user      lnk           // link to the device end
);
   // ****************************************
   // permit sequencer
   // ****************************************
   tcfe_pkg::tcfe_user_e state;
   tcfe_pkg::tcfe_user_e next_state;
   logic                 permit;
   logic                 next_permit;

   always_comb begin
      next_state  = state;
      next_permit = permit;
      case (state)
         tcfe_pkg::TCFE_U_IDLE: begin
            if (lnk.low_power_request_pin_n == tcfe_pkg::REQ_ASSERTED) begin
               next_state = tcfe_pkg::TCFE_U_HOUSEKEEP;
            end
         end
         tcfe_pkg::TCFE_U_HOUSEKEEP: begin
            if (lnk.low_power_request_pin_n == tcfe_pkg::REQ_IDLE) begin
               next_state = tcfe_pkg::TCFE_U_IDLE;
            end else if (!busy) begin
               next_state  = tcfe_pkg::TCFE_U_GRANT;
               next_permit = tcfe_pkg::PERMIT_ASSERTED;
            end
         end
         tcfe_pkg::TCFE_U_GRANT: begin
            if (lnk.low_power_request_pin_n == tcfe_pkg::REQ_IDLE) begin
               next_state  = tcfe_pkg::TCFE_U_REVOKE;
               next_permit = tcfe_pkg::PERMIT_IDLE;
            end
         end
         tcfe_pkg::TCFE_U_REVOKE: begin
            next_state = tcfe_pkg::TCFE_U_IDLE;
         end
         default: begin
            next_state  = tcfe_pkg::TCFE_U_IDLE;
            next_permit = tcfe_pkg::PERMIT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= tcfe_pkg::TCFE_U_IDLE;
         permit       <= tcfe_pkg::PERMIT_IDLE;
         permit_given <= tcfe_pkg::PERMIT_IDLE;
      end else begin
         state        <= next_state;
         permit       <= next_permit;
         permit_given <= next_permit;
      end
   end

   assign lnk.static_entry_permit = permit;
endmodule
`default_nettype wire

// ### sim/tcfe_checker.sv
// checker: timing relations on the freeze entry link
`timescale 1ns/1ps
`default_nettype none
module tcfe_checker (
   input  wire logic clk,                     // core clock
   input  wire logic rst_n,                   // async reset, active low
   input  wire logic low_power_request_pin_n, // board request, active low
   input  wire logic static_entry_permit,     // user permit, active high
   input  wire logic frozen                   // freeze indicator
);
   logic req_n;
   logic perm;
   assign req_n = low_power_request_pin_n;
   assign perm  = static_entry_permit;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_cause; frozen |-> !$past(req_n); endproperty
   a_cause: assert property (p_cause) else $error("freeze without request");
   property p_entry; !req_n && perm && !frozen |=> frozen; endproperty
   a_entry: assert property (p_entry) else $error("no freeze on both");
   property p_exit; req_n |=> !frozen; endproperty
   a_exit: assert property (p_exit) else $error("freeze kept after request idle");
   property p_revoke; $rose(req_n) && perm |=> !perm; endproperty
   a_revoke: assert property (p_revoke) else $error("permit not dropped");
   property p_drop; $fell(perm) |-> $past(req_n); endproperty
   a_drop: assert property (p_drop) else $error("permit dropped early");
   property p_regrant; req_n && !perm |=> !perm; endproperty
   a_regrant: assert property (p_regrant) else $error("permit without request");
   property p_grant; $rose(perm) |-> !$past(req_n); endproperty
   a_grant: assert property (p_grant) else $error("permit rose while idle");
   property p_hold; perm && !req_n |=> perm; endproperty
   a_hold: assert property (p_hold) else $error("permit glitched low");
endmodule
`default_nettype wire

// ### sim/two_condition_freeze_entry_test.sv
// testbench: both ends joined, random freeze walks
`timescale 1ns/1ps
`default_nettype none
module two_condition_freeze_entry_test;
   logic       clk, rst_n, busy, dual_mode, core_power, state_we, restore_we;
   logic       permit_given, frozen_out;
   logic [7:0] state_wdata, restore_data, state_q;
   int         error_cnt, checked, cycles;
   tcfe_if lnk ();
   tcfe_device u_tcfe_device (.clk(clk), .rst_n(rst_n), .dual_mode(dual_mode),
      .core_power(core_power), .state_we(state_we), .state_wdata(state_wdata),
      .restore_we(restore_we), .restore_data(restore_data), .state_q(state_q),
      .frozen_out(frozen_out), .lnk(lnk.device));
   tcfe_user u_tcfe_user (.clk(clk), .rst_n(rst_n), .busy(busy),
      .permit_given(permit_given), .lnk(lnk.user));
   tcfe_checker u_tcfe_checker (.clk(clk), .rst_n(rst_n),
      .low_power_request_pin_n(lnk.low_power_request_pin_n),
      .static_entry_permit(lnk.static_entry_permit), .frozen(lnk.frozen));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // ****************
   // checks and walks
   // ****************
   function automatic logic exp_frozen(input logic dual, input logic req_low, input logic pm);
      return req_low & (pm | ~dual);
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic walk(input logic dual, input int hk, input logic [7:0] d);
      @(negedge clk);
      dual_mode = dual;
      state_we = 1'h1;
      state_wdata = d;
      @(negedge clk);
      state_we = 1'h0;
      chk(state_q, d);
      lnk.low_power_request_pin_n = 1'h0;
      repeat (hk) begin
         @(negedge clk);
         chk(8'(frozen_out), 8'(exp_frozen(dual, 1'h1, 1'h0)));
      end
      busy = 1'h0;
      repeat (2) @(negedge clk);
      chk(8'(lnk.static_entry_permit), 8'h01);
      chk(8'(frozen_out), 8'(exp_frozen(dual, 1'h1, 1'h1)));
      lnk.low_power_request_pin_n = 1'h1;
      busy = 1'h1;
      state_we = 1'h1;
      state_wdata = ~d;
      repeat (2) begin
         @(negedge clk);
         state_we = 1'h0;
         chk(8'({lnk.frozen, permit_given}), 8'h00);
      end
      chk(state_q, d);
      $display("walk dual %0d done", dual);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      {rst_n, state_we, restore_we, state_wdata, restore_data} = 19'h0;
      {busy, dual_mode, core_power, lnk.low_power_request_pin_n} = 4'hF;
      {error_cnt, checked, cycles} = {32'h0, 32'h0, 32'h0};
      void'($urandom(20950));
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'h1;
      chk(8'(frozen_out), 8'h00);
      walk(1'h1, 1, 8'hFF);
      walk(1'h0, 1, 8'h00);
      repeat (20) walk(1'($urandom_range(1, 0)), $urandom_range(8, 1), 8'($urandom));
      @(negedge clk);
      state_we = 1'h1;
      state_wdata = 8'hC3;
      @(negedge clk);
      state_we = 1'h0;
      core_power = 1'h0;
      chk(state_q, 8'hC3);
      @(negedge clk);
      chk(state_q, 8'h00);
      core_power = 1'h1;
      @(negedge clk);
      restore_we = 1'h1;
      restore_data = 8'hA5;
      @(negedge clk);
      restore_we = 1'h0;
      chk(state_q, 8'hA5);
      $display("power loss test done");
      give_verdict();
   end
endmodule
`default_nettype wire
